// ### fsp_pkg.sv
// Shared constants and types for the flash self-program controller
package fsp_pkg;

  // ----------------------------------------------------------------
  // Special function register indices on the core side
  // ----------------------------------------------------------------
  localparam logic [2:0] SFR_ADDR_LOW = 3'h0;
  localparam logic [2:0] SFR_ADDR_HIGH = 3'h1;
  localparam logic [2:0] SFR_DATA_LOW = 3'h2;
  localparam logic [2:0] SFR_DATA_HIGH = 3'h3;
  localparam logic [2:0] SFR_CTRL = 3'h4;
  localparam logic [2:0] SFR_UNLOCK = 3'h5;

  // ----------------------------------------------------------------
  // Flash control register bit positions and reset value
  // ----------------------------------------------------------------
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_WR_EN = 2;
  localparam int CTL_WR_ERR = 3;
  localparam int CTL_ERASE = 4;
  localparam int CTL_LATCH_ONLY = 5;
  localparam int CTL_CFG_SEL = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Unlock keys and array shape
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int ROW_W = 4;
  localparam int LATCHES = 16;
  localparam int FLASH_WORDS = 32768;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;

  // ----------------------------------------------------------------
  // Erase and program time
  // ----------------------------------------------------------------
  localparam int ERASE_TIME_US = 2000;
  localparam int CLK_FREQ_MHZ = 100;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_FREQ_MHZ;
  localparam int CNT_W = 18;

  // ----------------------------------------------------------------
  // Host side AXI4-Lite map
  // ----------------------------------------------------------------
  localparam logic [7:0] AXI_SFR_LAST = 8'h14;
  localparam logic [7:0] AXI_HOST_CTRL = 8'h18;
  localparam logic [7:0] AXI_HOST_STATUS = 8'h1c;
  localparam int HCTL_INT_EN = 0;
  localparam int HCTL_CORE_RESET = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Controller sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RD1 = 6'b000010,
    ST_RD2 = 6'b000100,
    ST_WN1 = 6'b001000,
    ST_WN2 = 6'b010000,
    ST_BUSY = 6'b100000
  } fsp_state_type;

endpackage : fsp_pkg

// ### fsp_if.sv
// Link between the processor core side and the flash controller
`timescale 1ns/1ps
interface fsp_if;
  logic sfr_we;
  logic sfr_re;
  logic [2:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic force_nop;
  logic stall;
  logic core_reset;

  modport dev (
    input sfr_we, sfr_re, sfr_addr, sfr_wdata, core_reset,
    output sfr_rdata, force_nop, stall
  );
  modport core (
    output sfr_we, sfr_re, sfr_addr, sfr_wdata, core_reset,
    input sfr_rdata, force_nop, stall
  );
endinterface : fsp_if

// ### fsp_flash_ctrl.sv
// Flash self-program controller: read, unlock, erase, latch and program
//
// Function
// - Software loads address, clears config select, reads
// - Second cycle after read-start reads the array
// - Read data lands in data pair next cycle
// - Data pair holds until next read or write
// - Software places two NOPs after read-start
// - Erase, latch, program need completed unlock sequence
// - Unlock: 55h, AAh, set write-start, two NOPs
// - Write-start forces next two slots to NOP
// - Erase or program stalls core until done
// - Latch load forces two NOPs, no stall
// - Software masks interrupts around unlock sequence
// - Running code erases whole rows only
// - Erase: address, config clear, erase, enable, unlock
// - Erase: two setup cycles, then halt for timer
// - Erase resumes at third instruction after start
// - Start bits set by software, cleared by hardware
// - Writes need enable bit, clear after power-up
// - Reset during write sets write-error flag
// - Unlock register is write-only, reads zero
`timescale 1ns/1ps
module fsp_flash_ctrl #(
  parameter int ERASE_CYCLES_P = fsp_pkg::ERASE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  fsp_if.dev bus,
  output logic o_busy,
  output logic o_write_error
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsp_state_type st_q;
  logic [ADDR_W-1:0] flash_addr_q;
  logic [DATA_W-1:0] flash_data_q;
  logic rd_start_q;
  logic wr_start_q;
  logic write_enable_bit_q;
  logic write_error_flag_q;
  logic erase_select_q;
  logic latch_only_q;
  logic config_space_select_q;
  logic key1_seen_q;
  logic armed_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ROW_W:0] word_idx_q;
  logic [7:0] rdata_q;
  logic [DATA_W-1:0] flash_mem [0:FLASH_WORDS-1];
  logic [DATA_W-1:0] latch_q [0:LATCHES-1];

  function automatic logic sfr_hit(input logic stb, input logic [2:0] a,
                                   input logic [2:0] which);
    sfr_hit = stb && (a == which);
  endfunction : sfr_hit

  logic ctl_wr;
  logic unl_wr;
  logic start_wr;
  logic start_rd;
  logic latch_only;
  logic op_done;

  assign ctl_wr = sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_CTRL);
  assign unl_wr = sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_UNLOCK);
  // Start without arming or enable is dropped silently
  assign start_wr = ctl_wr && bus.sfr_wdata[CTL_WR] && armed_q &&
                    write_enable_bit_q && (st_q == ST_IDLE);
  assign start_rd = ctl_wr && bus.sfr_wdata[CTL_RD] && !start_wr &&
                    (st_q == ST_IDLE);
  // Erase wins over latch-only so a stray latch bit cannot skip it
  assign latch_only = latch_only_q && !erase_select_q;
  assign op_done = (st_q == ST_BUSY) && (cnt_q == '0);

  // ----------------------------------------------------------------
  // Core handshake
  // ----------------------------------------------------------------
  assign bus.force_nop = (st_q == ST_RD2) || (st_q == ST_WN1) ||
                         (st_q == ST_WN2);
  assign bus.stall = (st_q == ST_BUSY);
  assign bus.sfr_rdata = rdata_q;
  assign o_busy = (st_q != ST_IDLE);
  assign o_write_error = write_error_flag_q;

  // ----------------------------------------------------------------
  // Unlock detector
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || bus.core_reset) begin
      key1_seen_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (unl_wr) begin
      key1_seen_q <= (bus.sfr_wdata == UNLOCK_KEY1);
      armed_q <= key1_seen_q && (bus.sfr_wdata == UNLOCK_KEY2);
    end else if (bus.sfr_we) begin
      // The start write itself also consumes the arming
      key1_seen_q <= 1'b0;
      armed_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rd_start_q <= CTRL_RESET[CTL_RD];
      wr_start_q <= CTRL_RESET[CTL_WR];
      write_enable_bit_q <= CTRL_RESET[CTL_WR_EN];
      write_error_flag_q <= CTRL_RESET[CTL_WR_ERR];
      erase_select_q <= CTRL_RESET[CTL_ERASE];
      latch_only_q <= CTRL_RESET[CTL_LATCH_ONLY];
      config_space_select_q <= CTRL_RESET[CTL_CFG_SEL];
    end else if (bus.core_reset) begin
      rd_start_q <= 1'b0;
      wr_start_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
      erase_select_q <= 1'b0;
      latch_only_q <= 1'b0;
      config_space_select_q <= 1'b0;
      if (wr_start_q) begin
        write_error_flag_q <= 1'b1;
      end
    end else begin
      if (ctl_wr) begin
        write_enable_bit_q <= bus.sfr_wdata[CTL_WR_EN];
        write_error_flag_q <= bus.sfr_wdata[CTL_WR_ERR];
        erase_select_q <= bus.sfr_wdata[CTL_ERASE];
        latch_only_q <= bus.sfr_wdata[CTL_LATCH_ONLY];
        config_space_select_q <= bus.sfr_wdata[CTL_CFG_SEL];
      end
      // Software can only set; hardware clears at completion
      if (start_rd) begin
        rd_start_q <= 1'b1;
      end else if (st_q == ST_RD2) begin
        rd_start_q <= 1'b0;
      end
      if (start_wr) begin
        wr_start_q <= 1'b1;
      end else if (op_done || (st_q == ST_WN2 && latch_only)) begin
        wr_start_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || bus.core_reset) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_wr) begin
            st_q <= ST_WN1;
          end else if (start_rd) begin
            st_q <= ST_RD1;
          end
        end
        ST_RD1: st_q <= ST_RD2;
        ST_RD2: st_q <= ST_IDLE;
        ST_WN1: st_q <= ST_WN2;
        ST_WN2: begin
          if (latch_only) begin
            st_q <= ST_IDLE;
          end else begin
            st_q <= ST_BUSY;
            cnt_q <= CNT_W'(ERASE_CYCLES_P - 1);
          end
        end
        ST_BUSY: begin
          if (cnt_q == '0) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address and data pairs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      flash_addr_q <= '0;
      flash_data_q <= '0;
    end else begin
      if (sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_ADDR_LOW)) begin
        flash_addr_q[7:0] <= bus.sfr_wdata;
      end
      if (sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_ADDR_HIGH)) begin
        flash_addr_q[ADDR_W-1:8] <= bus.sfr_wdata[ADDR_W-9:0];
      end
      if (st_q == ST_RD2) begin
        // Configuration space is not modelled and reads as zero
        flash_data_q <= config_space_select_q ? '0 :
                        flash_mem[flash_addr_q];
      end else if (sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_DATA_LOW)) begin
        flash_data_q[7:0] <= bus.sfr_wdata;
      end else if (sfr_hit(bus.sfr_we, bus.sfr_addr, SFR_DATA_HIGH)) begin
        flash_data_q[DATA_W-1:8] <= bus.sfr_wdata[DATA_W-9:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (bus.sfr_re) begin
      case (bus.sfr_addr)
        SFR_ADDR_LOW: rdata_q <= flash_addr_q[7:0];
        SFR_ADDR_HIGH: rdata_q <= {1'b0, flash_addr_q[ADDR_W-1:8]};
        SFR_DATA_LOW: rdata_q <= flash_data_q[7:0];
        SFR_DATA_HIGH: rdata_q <= {2'b00, flash_data_q[DATA_W-1:8]};
        SFR_CTRL: rdata_q <= {1'b0, config_space_select_q, latch_only_q,
                              erase_select_q, write_error_flag_q,
                              write_enable_bit_q, wr_start_q, rd_start_q};
        SFR_UNLOCK: rdata_q <= 8'h00;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write latches and array
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || op_done) begin
      for (int i = 0; i < LATCHES; i++) begin
        latch_q[i] <= BLANK_WORD;
      end
    end else if (st_q == ST_WN2 && latch_only) begin
      latch_q[flash_addr_q[ROW_W-1:0]] <= flash_data_q;
    end
  end

  // One word of the row per busy cycle; the timer is far longer than a row
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || st_q != ST_BUSY) begin
      word_idx_q <= '0;
    end else if (!word_idx_q[ROW_W]) begin
      word_idx_q <= word_idx_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (st_q == ST_BUSY && !word_idx_q[ROW_W] && !config_space_select_q) begin
      // Whole row addressed by upper bits, never a single word
      flash_mem[{flash_addr_q[ADDR_W-1:ROW_W], word_idx_q[ROW_W-1:0]}] <=
        erase_select_q ? BLANK_WORD : latch_q[word_idx_q[ROW_W-1:0]];
    end
  end

endmodule : fsp_flash_ctrl

// ### fsp_core_port.sv
// Processor core end: AXI4-Lite slave issuing register slots to the flash
`timescale 1ns/1ps
module fsp_core_port (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_int_en,
  fsp_if.core bus
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // Request holding
  // ----------------------------------------------------------------
  logic aw_q;
  logic w_q;
  logic ar_q;
  logic [7:0] awaddr_q;
  logic [7:0] araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rd_pend_q;
  logic pend_sfr_q;
  logic [7:0] local_q;
  logic [1:0] pend_resp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic int_en_q;
  logic core_reset_q;

  function automatic logic is_sfr(input logic [7:0] a);
    is_sfr = (a <= AXI_SFR_LAST) && (a[1:0] == 2'b00);
  endfunction : is_sfr

  // Slots forced to NOP or stalled carry no register access; host
  // registers bypass the slot so a core reset can cut a stall short
  logic slot_free;
  logic wr_go;
  logic rd_go;
  assign slot_free = !bus.force_nop && !bus.stall;
  assign wr_go = aw_q && w_q && !bvalid_q &&
                 (slot_free || !is_sfr(awaddr_q));
  assign rd_go = ar_q && !rd_pend_q && !rvalid_q && !wr_go &&
                 (slot_free || !is_sfr(araddr_q));

  assign o_axi_awready = !aw_q;
  assign o_axi_wready = !w_q;
  assign o_axi_arready = !ar_q;
  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp = bresp_q;
  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rdata = rdata_q;
  assign o_axi_rresp = rresp_q;
  assign o_int_en = int_en_q;

  assign bus.sfr_we = wr_go && is_sfr(awaddr_q) && wstrb_q[0];
  assign bus.sfr_re = rd_go && is_sfr(araddr_q);
  assign bus.sfr_addr = wr_go ? awaddr_q[4:2] : araddr_q[4:2];
  assign bus.sfr_wdata = wdata_q[7:0];
  assign bus.core_reset = core_reset_q;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (i_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= i_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (i_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wdata_q <= i_axi_wdata;
        wstrb_q <= i_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (is_sfr(awaddr_q) || awaddr_q == AXI_HOST_CTRL ||
                    awaddr_q == AXI_HOST_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Host control: interrupt enable and core reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      int_en_q <= 1'b0;
      core_reset_q <= 1'b0;
    end else begin
      core_reset_q <= 1'b0;
      if (wr_go && awaddr_q == AXI_HOST_CTRL && wstrb_q[0]) begin
        int_en_q <= wdata_q[HCTL_INT_EN];
        core_reset_q <= wdata_q[HCTL_CORE_RESET];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ar_q <= 1'b0;
      araddr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      pend_sfr_q <= 1'b0;
      local_q <= 8'h00;
      pend_resp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      if (i_axi_arvalid && !ar_q) begin
        ar_q <= 1'b1;
        araddr_q <= i_axi_araddr;
      end else if (rd_go) begin
        ar_q <= 1'b0;
      end
      rd_pend_q <= rd_go;
      if (rd_go) begin
        pend_sfr_q <= is_sfr(araddr_q);
        pend_resp_q <= RESP_OKAY;
        if (araddr_q == AXI_HOST_CTRL) begin
          local_q <= {7'h00, int_en_q};
        end else if (araddr_q == AXI_HOST_STATUS) begin
          local_q <= {6'h00, bus.stall, bus.force_nop};
        end else begin
          local_q <= 8'h00;
          if (!is_sfr(araddr_q)) begin
            pend_resp_q <= RESP_SLVERR;
          end
        end
      end
      if (rd_pend_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h0, pend_sfr_q ? bus.sfr_rdata : local_q};
        rresp_q <= pend_resp_q;
      end else if (i_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule : fsp_core_port

// ### fsp_properties.sv
// Interface checker for the flash self-program link
`timescale 1ns/1ps
module fsp_properties #(
  parameter int ERASE_CYCLES_P = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [2:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic force_nop,
  input wire logic stall,
  input wire logic core_reset
);
  import fsp_pkg::*;
  logic key_q;
  logic armed_q;
  logic wr_en_q;
  logic abort_q;
  int stall_cnt_q;
  logic ctl_we;
  logic start;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // Shadow of the unlock state, rebuilt from the slot traffic
  // ----------------------------------------------------------------
  assign ctl_we = sfr_we && sfr_addr == SFR_CTRL;
  assign start = ctl_we && sfr_wdata[CTL_WR] && armed_q && wr_en_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || core_reset) begin
      key_q <= 1'b0;
      armed_q <= 1'b0;
      wr_en_q <= 1'b0;
    end else if (sfr_we) begin
      key_q <= sfr_addr == SFR_UNLOCK && sfr_wdata == UNLOCK_KEY1;
      armed_q <= key_q && sfr_addr == SFR_UNLOCK && sfr_wdata == UNLOCK_KEY2;
      if (sfr_addr == SFR_CTRL) begin
        wr_en_q <= sfr_wdata[CTL_WR_EN];
      end
    end
  end
  // Abort cuts a stall short, so its length is not judged then
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      abort_q <= 1'b0;
      stall_cnt_q <= 0;
    end else begin
      abort_q <= core_reset || (abort_q && stall);
      stall_cnt_q <= stall ? stall_cnt_q + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  slot_free_a: assert property (
    (sfr_we || sfr_re) |-> !force_nop && !stall
  ) else $error("slot issued while blocked");
  rd_nop_a: assert property (
    ctl_we && sfr_wdata[CTL_RD] && !sfr_wdata[CTL_WR]
    |=> !force_nop ##1 force_nop ##1 !force_nop
  ) else $error("read did not take the second slot");
  wr_nop_a: assert property (
    start |=> force_nop [*2]
  ) else $error("write start without two forced slots");
  no_start_a: assert property (
    ctl_we && sfr_wdata[CTL_WR] && !sfr_wdata[CTL_RD] && !(armed_q && wr_en_q)
    |=> !force_nop && !stall
  ) else $error("write started without unlock");
  latch_go_a: assert property (
    start && sfr_wdata[CTL_LATCH_ONLY] && !sfr_wdata[CTL_ERASE]
    |=> force_nop [*2] ##1 (!force_nop && !stall)
  ) else $error("latch load stalled");
  erase_stall_a: assert property (
    start && (sfr_wdata[CTL_ERASE] || !sfr_wdata[CTL_LATCH_ONLY])
    |=> force_nop [*2] ##1 stall
  ) else $error("erase or program did not stall");
  stall_len_a: assert property (
    $fell(stall) && !abort_q |-> stall_cnt_q == ERASE_CYCLES_P
  ) else $error("stall length wrong");
  resume_a: assert property (
    $fell(stall) |-> !force_nop
  ) else $error("slot after stall is blocked");
  unlock_zero_a: assert property (
    sfr_re && sfr_addr == SFR_UNLOCK |=> sfr_rdata == 8'h00
  ) else $error("unlock register read not zero");
  abort_idle_a: assert property (
    core_reset |-> ##[1:2] (!stall && !force_nop)
  ) else $error("core reset did not abort");
endmodule : fsp_properties

// ### tb_top.sv
// Testbench driving the AXI4-Lite end of the flash self-program link
`timescale 1ns/1ps
module tb_top;
  import fsp_pkg::*;
  localparam int ERASE_P = 32;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, int_en, busy, werr;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  int fails = 0;
  int checks = 0;
  always #5 i_mclk = ~i_mclk;
  fsp_if fsp_if_i ();
  fsp_flash_ctrl #(.ERASE_CYCLES_P(ERASE_P)) fsp_flash_ctrl_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(fsp_if_i),
    .o_busy(busy), .o_write_error(werr));
  fsp_core_port fsp_core_port_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid),
    .i_axi_bready(bready), .o_axi_bresp(bresp), .i_axi_arvalid(arvalid),
    .o_axi_arready(arready), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .o_int_en(int_en), .bus(fsp_if_i));
  fsp_properties #(.ERASE_CYCLES_P(ERASE_P)) fsp_properties_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .sfr_we(fsp_if_i.sfr_we),
    .sfr_re(fsp_if_i.sfr_re), .sfr_addr(fsp_if_i.sfr_addr),
    .sfr_wdata(fsp_if_i.sfr_wdata), .sfr_rdata(fsp_if_i.sfr_rdata),
    .force_nop(fsp_if_i.force_nop), .stall(fsp_if_i.stall),
    .core_reset(fsp_if_i.core_reset));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    while (!(ad && wd)) begin
      @(posedge i_mclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge i_mclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge i_mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge i_mclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic unlock();
    wr(8'h14, UNLOCK_KEY1);
    wr(8'h14, UNLOCK_KEY2);
  endtask : unlock
  // The forced NOP slot (the second) is left to the hardware: the core port never issues in it
  task automatic rd_flash(input logic [14:0] a, input logic [13:0] e);
    logic [31:0] d;
    wr(8'h00, a[7:0]);
    wr(8'h04, {1'b0, a[14:8]});
    wr(8'h10, 8'h01);
    rd(8'h08, d);
    chk("data low", d, {24'h0, e[7:0]});
    rd(8'h0c, d);
    chk("data high", d, {26'h0, e[13:8]});
    rd(8'h08, d);
    chk("data low held", d, {24'h0, e[7:0]});
  endtask : rd_flash
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    rd(8'h10, d);
    chk("ctrl reset", d, 32'h0);
    chk("error pin reset", {31'h0, werr}, 32'h0);
    wr(8'h14, UNLOCK_KEY1);
    rd(8'h14, d);
    chk("unlock read", d, 32'h0);
    rd(8'h20, d);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h20, 8'h00);
    chk("unmapped wr resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask : t_reset
  task automatic t_int_en();
    logic [31:0] d;
    wr(8'h18, 8'h01);
    rd(8'h18, d);
    chk("int enable set", {d[0], int_en}, 32'h3);
    wr(8'h18, 8'h00);
    chk("int enable clear", {31'h0, int_en}, 32'h0);
  endtask : t_int_en
  task automatic t_program();
    logic [31:0] d;
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h34);
    wr(8'h0c, 8'h12);
    wr(8'h10, 8'h24);
    unlock();
    wr(8'h10, 8'h26);
    chk("latch busy", {31'h0, busy}, 32'h1);
    rd(8'h10, d);
    chk("latch done", d, 32'h24);
    wr(8'h10, 8'h04);
    unlock();
    wr(8'h10, 8'h06);
    chk("program busy", {31'h0, busy}, 32'h1);
    rd(8'h10, d);
    chk("program done", d, 32'h04);
    rd_flash(15'h0003, 14'h1234);
    rd_flash(15'h0004, BLANK_WORD);
    rd(8'h10, d);
    chk("read done", d, 32'h0);
  endtask : t_program
  task automatic t_erase();
    logic [31:0] d;
    wr(8'h10, 8'h14);
    unlock();
    wr(8'h10, 8'h16);
    chk("erase busy", {31'h0, busy}, 32'h1);
    rd(8'h1c, d);
    chk("status stall", d, 32'h2);
    rd_flash(15'h0003, BLANK_WORD);
  endtask : t_erase
  // Broken sequences: wrong order, no enable, repeated key, gap write
  task automatic t_bad();
    logic [31:0] d;
    logic [7:0] k1 [4] = '{8'haa, 8'h55, 8'h55, 8'h55};
    logic [7:0] k2 [4] = '{8'h55, 8'haa, 8'h55, 8'haa};
    logic [7:0] en [4] = '{8'h14, 8'h10, 8'h14, 8'h14};
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, en[i]);
      wr(8'h14, k1[i]);
      if (i == 3) begin
        wr(8'h00, 8'h03);
      end
      wr(8'h14, k2[i]);
      wr(8'h10, 8'h16);
      chk("bad unlock busy", {31'h0, busy}, 32'h0);
      rd(8'h10, d);
      chk("bad unlock ctrl", d, 32'h14);
    end
  endtask : t_bad
  task automatic t_abort();
    logic [31:0] d;
    wr(8'h10, 8'h14);
    unlock();
    wr(8'h10, 8'h16);
    wr(8'h18, 8'h02);
    rd(8'h10, d);
    chk("error ctrl", d, 32'h08);
    chk("error pin", {31'h0, werr}, 32'h1);
    wr(8'h10, 8'h00);
    rd(8'h10, d);
    chk("error cleared", d, 32'h0);
  endtask : t_abort
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    t_reset();
    t_int_en();
    t_program();
    t_erase();
    t_bad();
    t_abort();
    conclude();
  end
  // Whole run needs well under a thousand cycles; this leaves wide margin
  initial begin
    #200us;
    fails++;
    conclude();
  end
endmodule : tb_top
